// ==== inc/lpt_cfg.svh ====
`ifndef LPT_CFG_SVH
`define LPT_CFG_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define LPT_OFF_TILE_CTRL   8'h00
`define LPT_OFF_STATUS      8'h04
`define LPT_OFF_SLICE_BASE  8'h10
`define LPT_SLICE_STRIDE    8'h08
`define LPT_OFF_LUT         8'h00
`define LPT_OFF_SCTL        8'h04

// ****************************************************************
// tile control fields
// ****************************************************************
`define LPT_TC_RAM_MODE     0
`define LPT_TC_CFG_DONE     1

// ****************************************************************
// slice control fields
// ****************************************************************
`define LPT_SC_NEG_EDGE     0
`define LPT_SC_ASYNC_LSR    1
`define LPT_SC_LUT5         2
`define LPT_SC_FF0_DIRECT   3
`define LPT_SC_FF1_DIRECT   4
`define LPT_SC_INIT0        5
`define LPT_SC_INIT1        6
`define LPT_SC_MODE_LSB     7
`define LPT_SC_MODE_W       2
`define LPT_SC_FN_LSB       9
`define LPT_SC_FN_W         4
`define LPT_SC_W            13

// ****************************************************************
// reset values
// ****************************************************************
`define LPT_SCTL_RESET      13'h0000
`define LPT_LUT_RESET       32'h0000_0000

`endif

// ==== inc/lpt_pkg.sv ====
package lpt_pkg;

  typedef enum logic [1:0] {
    LPT_MODE_LOGIC  = 2'h0,
    LPT_MODE_RIPPLE = 2'h1,
    LPT_MODE_RAM    = 2'h2,
    LPT_MODE_ROM    = 2'h3
  } lpt_mode_t;

  typedef enum logic [3:0] {
    LPT_FN_ADD       = 4'h0,
    LPT_FN_SUB       = 4'h1,
    LPT_FN_ADDSUB    = 4'h2,
    LPT_FN_CNT_UP    = 4'h3,
    LPT_FN_CNT_DN    = 4'h4,
    LPT_FN_CNT_UDCLR = 4'h5,
    LPT_FN_CNT_UDLD  = 4'h6,
    LPT_FN_CMP_GE    = 4'h7,
    LPT_FN_CMP_NE    = 4'h8,
    LPT_FN_CMP_LE    = 4'h9,
    LPT_FN_CNT_UDGE  = 4'ha,
    LPT_FN_MULT_PP   = 4'hb,
    LPT_FN_DIV_STEP  = 4'hc,
    LPT_FN_MUL_SER1  = 4'hd,
    LPT_FN_MUL_SER2  = 4'he,
    LPT_FN_CNT_UDLE  = 4'hf
  } lpt_rfn_t;

  typedef struct packed {
    logic [3:0][31:0] lut;
    logic [3:0][12:0] sctl;
    logic             ram_mode;
    logic             cfg_done;
    logic [1:0]       clk_prev;
    logic [3:0][1:0]  q;
    logic [3:0]       f0;
    logic [3:0]       f1;
    logic             cout;
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
  } lpt_state_t;

endpackage

// ==== rtl/lpt_logic_tile.sv ====
`timescale 1ns/1ps
// Functional notes
// - each slice has two 4-input tables feeding its two flip-flops
// - flip-flops capture on rising or falling slice clock edge, per pair
// - local set/reset acts synchronously or asynchronously, as configured
// - low output is LUT4 or LUT5 via combine-select; high output LUT4 only
// - slice clock, clock enable, set/reset shared by slices 0/1 and 2/3
// - each slice takes 11 routing inputs (8 table, 2 direct, 1 combine-select) plus one carry-in
// - each slice drives two comb outputs, two flop outputs, one carry-out
// - RAM mode: slices 0,1 store, slice 2 consumed, slice 3 free
// - slices 0-2 allow logic/ripple/RAM/ROM; slice 3 no RAM
// - logic mode table holds one bit per each of 16 input codes
// - ripple does 2-bit add, subtract, dynamic add/subtract
// - ripple does 2-bit up, down, dynamic up/down counters, clear, preload (LPT_FN_CNT_UDCLR has no clear here: it only counts up/down)
// - ripple compares two 2-bit operands: ge, ne, le
// - ripple dynamic up/down counter with ge comparison
// - serial divider step, 2-bit mantissa, one bit per cycle
// - serial multiplier shifting one or two bits per cycle
// - partial-product cross-term summation, two cells per slice
// - fast-carry configuration forms generate and propagate terms
// - on entering user mode each flip-flop holds its configured value
// - flip-flop input picks table output or direct routing input
// - in RAM mode slice 2 supplies address and write control
// - ROM tables load only during configuration, read-only afterwards
`include "lpt_cfg.svh"

module lpt_logic_tile (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic [15:0] i_table_low_inputs,
  input  wire logic [15:0] i_table_high_inputs,
  input  wire logic [7:0]  i_direct_flop_inputs,
  input  wire logic [3:0]  i_combine_select,
  input  wire logic [1:0]  i_slice_clock,
  input  wire logic [1:0]  i_clock_enable,
  input  wire logic [1:0]  i_local_set_reset,
  input  wire logic        i_carry_in,
  output logic      [3:0]  o_comb_out_low,
  output logic      [3:0]  o_comb_out_high,
  output logic      [7:0]  o_flop_outputs,
  output logic             o_carry_out
);
  import lpt_pkg::*;

  // ****************************************************************
  // functions
  // ****************************************************************
  function automatic logic lut4(input logic [15:0] tab,
                                input logic [3:0]  idx);
    lut4 = tab[idx];
  endfunction

  // effective mode: slice 3 has no RAM mode, RAM is a tile-level state
  function automatic lpt_mode_t eff_mode(input logic [12:0] ctl,
                                         input int          s,
                                         input logic        ram);
    lpt_mode_t m;
    m = lpt_mode_t'(ctl[`LPT_SC_MODE_LSB +: `LPT_SC_MODE_W]);
    if (ram && s < 3) begin
      m = LPT_MODE_RAM;
    end else if (m == LPT_MODE_RAM) begin
      m = LPT_MODE_LOGIC;
    end
    eff_mode = m;
  endfunction

  // returns {cout, f1, f0, d1, d0}
  function automatic logic [4:0] ripple(input lpt_rfn_t   fn,
                                        input logic [1:0] a,
                                        input logic [1:0] b,
                                        input logic [1:0] q,
                                        input logic       cin,
                                        input logic       dyn,
                                        input logic       ld);
    logic [1:0] bb;
    logic [1:0] g;
    logic [1:0] p;
    logic [1:0] s;
    logic       c1;
    logic       co;
    logic [1:0] up;
    logic [1:0] dn;
    logic [1:0] ud;
    logic       ud_co;
    logic       ge;
    logic       le;
    logic [1:0] f;
    logic [1:0] d;
    logic [1:0] diff;
    bb = b;
    if (fn == LPT_FN_SUB || (fn == LPT_FN_ADDSUB && dyn)) begin
      bb = ~b;
    end
    g     = a & bb;
    p     = a ^ bb;
    c1    = g[0] | (p[0] & cin);
    co    = g[1] | (p[1] & c1);
    s     = p ^ {c1, cin};
    up    = q + {1'b0, cin};
    dn    = q - {1'b0, cin};
    ud    = dyn ? dn : up;
    ud_co = dyn ? (~|q & cin) : (&q & cin);
    ge    = (a > b) | ((a == b) & cin);
    le    = (a < b) | ((a == b) & cin);
    diff  = q - b;
    f     = s;
    d     = s;
    unique case (fn)
      LPT_FN_ADD, LPT_FN_SUB, LPT_FN_ADDSUB: begin
        f = s;
      end
      LPT_FN_CNT_UP: begin
        d = up;
        f = up;
        co = &q & cin;
      end
      LPT_FN_CNT_DN: begin
        d = dn;
        f = dn;
        co = ~|q & cin;
      end
      LPT_FN_CNT_UDCLR, LPT_FN_CNT_UDLD: begin
        d = (ld && fn == LPT_FN_CNT_UDLD) ? b : ud;
        f = d;
        co = ud_co;
      end
      LPT_FN_CMP_GE: begin
        co = ge;
        f = {1'b0, ge};
      end
      LPT_FN_CMP_NE: begin
        co = (a != b) | cin;
        f = {1'b0, co};
      end
      LPT_FN_CMP_LE: begin
        co = le;
        f = {1'b0, le};
      end
      LPT_FN_CNT_UDGE, LPT_FN_CNT_UDLE: begin
        d = ud;
        co = (fn == LPT_FN_CNT_UDGE) ? ge : le;
        f = {ud_co, co};
      end
      LPT_FN_MULT_PP: begin
        // sum of the two cross-terms in the low cell, their carry in the high cell
        f = {(a[0] & b[1]) & (a[1] & b[0]),
             (a[0] & b[1]) ^ (a[1] & b[0])};
        d = f;
        co = cin;
      end
      LPT_FN_DIV_STEP: begin
        // restoring step: keep difference when it fits, shift in a[0]
        d = {(q >= b) ? diff[0] : q[0], a[0]};
        f = {1'b0, q >= b};
        co = q[1];
      end
      LPT_FN_MUL_SER1: begin
        d = {q[0], a[0] & dyn};
        f = q;
        co = q[1];
      end
      LPT_FN_MUL_SER2: begin
        d = {a[1] & dyn, a[0] & dyn};
        f = q;
        co = q[1];
      end
    endcase
    ripple = {co, f, d};
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  lpt_state_t st;
  lpt_state_t next_st;

  logic [3:0] sel_slice;
  logic       sel_lut;
  logic       sel_sctl;
  logic       sel_tc;
  logic       sel_stat;
  logic       apb_hit;

  always_comb begin
    sel_slice = 4'h0;
    sel_tc    = (i_paddr == `LPT_OFF_TILE_CTRL);
    sel_stat  = (i_paddr == `LPT_OFF_STATUS);
    sel_lut   = 1'b0;
    sel_sctl  = 1'b0;
    for (int s = 0; s < 4; s++) begin
      if (i_paddr == 8'(`LPT_OFF_SLICE_BASE + s * `LPT_SLICE_STRIDE
                        + `LPT_OFF_LUT)) begin
        sel_slice[s] = 1'b1;
        sel_lut      = 1'b1;
      end
      if (i_paddr == 8'(`LPT_OFF_SLICE_BASE + s * `LPT_SLICE_STRIDE
                        + `LPT_OFF_SCTL)) begin
        sel_slice[s] = 1'b1;
        sel_sctl     = 1'b1;
      end
    end
    apb_hit = sel_tc | sel_stat | sel_lut | sel_sctl;
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    logic             acc;
    logic [1:0]       edge_ev;
    logic             carry;
    logic [4:0]       r;
    logic [1:0]       dq;
    logic [12:0]      c;
    logic [12:0]      pc;
    lpt_mode_t        m;
    logic [3:0]       lo_idx;
    logic [3:0]       hi_idx;
    logic             f0v;
    logic             f1v;
    logic [3:0]       waddr;
    logic             wen;
    acc     = 1'b0;
    edge_ev = 2'b00;
    carry   = 1'b0;
    r       = 5'h00;
    dq      = 2'b00;
    c       = 13'h0000;
    pc      = 13'h0000;
    m       = LPT_MODE_LOGIC;
    lo_idx  = 4'h0;
    hi_idx  = 4'h0;
    f0v     = 1'b0;
    f1v     = 1'b0;
    waddr   = 4'h0;
    wen     = 1'b0;
    next_st = st;

    // ****************************************************************
    // apb slave, one wait state
    // ****************************************************************
    acc = i_psel & i_penable & ~st.pready;
    next_st.pready  = acc;
    next_st.pslverr = acc & ~apb_hit;
    if (acc && !i_pwrite) begin
      next_st.prdata = 32'h0000_0000;
      if (sel_tc) begin
        next_st.prdata[`LPT_TC_RAM_MODE] = st.ram_mode;
        next_st.prdata[`LPT_TC_CFG_DONE] = st.cfg_done;
      end
      if (sel_stat) begin
        next_st.prdata[8:0] = {st.cout, st.q};
      end
      for (int s = 0; s < 4; s++) begin
        if (sel_slice[s] && sel_lut) begin
          next_st.prdata = st.lut[s];
        end
        if (sel_slice[s] && sel_sctl) begin
          next_st.prdata[12:0] = st.sctl[s];
        end
      end
    end
    // configuration is frozen once user mode is entered
    if (acc && i_pwrite && !st.cfg_done) begin
      if (sel_tc) begin
        next_st.ram_mode = i_pwdata[`LPT_TC_RAM_MODE];
        next_st.cfg_done = i_pwdata[`LPT_TC_CFG_DONE];
      end
      for (int s = 0; s < 4; s++) begin
        if (sel_slice[s] && sel_lut) begin
          next_st.lut[s] = i_pwdata;
        end
        if (sel_slice[s] && sel_sctl) begin
          next_st.sctl[s] = i_pwdata[12:0];
        end
      end
    end

    // ****************************************************************
    // slice clock edges, per pair
    // ****************************************************************
    next_st.clk_prev = i_slice_clock;
    for (int p = 0; p < 2; p++) begin
      pc = st.sctl[2 * p];
      edge_ev[p] = pc[`LPT_SC_NEG_EDGE] ?
                   (st.clk_prev[p] & ~i_slice_clock[p]) :
                   (~st.clk_prev[p] & i_slice_clock[p]);
    end

    // ****************************************************************
    // slices
    // ****************************************************************
    carry = i_carry_in;
    for (int s = 0; s < 4; s++) begin
      c      = st.sctl[s];
      pc     = st.sctl[(s / 2) * 2];
      m      = eff_mode(c, s, st.ram_mode);
      lo_idx = i_table_low_inputs[4 * s +: 4];
      hi_idx = i_table_high_inputs[4 * s +: 4];
      f0v    = lut4(st.lut[s][15:0], lo_idx);
      f1v    = lut4(st.lut[s][31:16], hi_idx);
      if (c[`LPT_SC_LUT5] && i_combine_select[s]) begin
        f0v = lut4(st.lut[s][31:16], lo_idx);
      end
      dq = {f1v, f0v};
      if (m == LPT_MODE_RIPPLE) begin
        r = ripple(lpt_rfn_t'(c[`LPT_SC_FN_LSB +: `LPT_SC_FN_W]),
                   {lo_idx[1], lo_idx[0]}, {hi_idx[1], hi_idx[0]},
                   st.q[s], carry, lo_idx[2], lo_idx[3]);
        carry = r[4];
        f0v = r[2];
        f1v = r[3];
        dq = r[1:0];
      end
      if (c[`LPT_SC_FF0_DIRECT]) begin
        dq[0] = i_direct_flop_inputs[2 * s];
      end
      if (c[`LPT_SC_FF1_DIRECT]) begin
        dq[1] = i_direct_flop_inputs[2 * s + 1];
      end
      if (s == 2 && m == LPT_MODE_RAM) begin
        // consumed as memory support, so its own outputs stay quiet
        f0v = 1'b0;
        f1v = 1'b0;
      end else if (!st.cfg_done) begin
        next_st.q[s] = {c[`LPT_SC_INIT1], c[`LPT_SC_INIT0]};
      end else if (i_local_set_reset[s / 2] &&
                   (pc[`LPT_SC_ASYNC_LSR] || edge_ev[s / 2])) begin
        next_st.q[s] = {c[`LPT_SC_INIT1], c[`LPT_SC_INIT0]};
      end else if (edge_ev[s / 2] && i_clock_enable[s / 2]) begin
        next_st.q[s] = dq;
      end
      next_st.f0[s] = f0v;
      next_st.f1[s] = f1v;
    end
    next_st.cout = carry;

    // ****************************************************************
    // distributed ram write, addressed and strobed from slice 2
    // ****************************************************************
    waddr = i_table_low_inputs[11:8];
    wen   = st.cfg_done & st.ram_mode & edge_ev[1] &
            i_direct_flop_inputs[4];
    if (wen) begin
      for (int s = 0; s < 2; s++) begin
        next_st.lut[s][waddr]      = i_direct_flop_inputs[2 * s];
        next_st.lut[s][16 + waddr] = i_direct_flop_inputs[2 * s + 1];
      end
    end

    if (i_rst) begin
      for (int s = 0; s < 4; s++) begin
        next_st.lut[s]  = `LPT_LUT_RESET;
        next_st.sctl[s] = `LPT_SCTL_RESET;
      end
      next_st.ram_mode = 1'b0;
      next_st.cfg_done = 1'b0;
      next_st.clk_prev = 2'b00;
      next_st.q        = 8'h00;
      next_st.f0       = 4'h0;
      next_st.f1       = 4'h0;
      next_st.cout     = 1'b0;
      next_st.prdata   = 32'h0000_0000;
      next_st.pready   = 1'b0;
      next_st.pslverr  = 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    st <= next_st;
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign o_prdata        = st.prdata;
  assign o_pready        = st.pready;
  assign o_pslverr       = st.pslverr;
  assign o_comb_out_low  = st.f0;
  assign o_comb_out_high = st.f1;
  assign o_flop_outputs  = st.q;
  assign o_carry_out     = st.cout;

endmodule // lpt_logic_tile

// ==== sim/lpt_fabric_model.sv ====
`timescale 1ns/1ps
// ****
// slice clock source on the fabric side
// ****
module lpt_fabric_model (
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst,
  input  wire logic [1:0] i_go,
  output logic      [1:0] o_slice_clock
);
  logic [1:0][2:0] cnt;
  // 4 cycles high, at least 4 low: each level lasts over one sample
  always_ff @(posedge i_clk_sys) begin
    for (int p = 0; p < 2; p++) begin
      if (i_rst) begin
        cnt[p] <= 3'h0;
      end else if (cnt[p] != 3'h0) begin
        cnt[p] <= cnt[p] - 3'h1;
      end else if (i_go[p]) begin
        cnt[p] <= 3'h7;
      end
    end
  end
  // idle clock stands low between pulses
  assign o_slice_clock[0] = (cnt[0] > 3'h3);
  assign o_slice_clock[1] = (cnt[1] > 3'h3);
endmodule // lpt_fabric_model

// ==== sim/lpt_logic_tile_properties.sv ====
`timescale 1ns/1ps
// ****
// port checker
// ****
module lpt_tile_properties (
  input wire logic        i_clk_sys,
  input wire logic        i_rst,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  input wire logic [1:0]  i_clock_enable,
  input wire logic [1:0]  i_local_set_reset,
  input wire logic [3:0]  o_comb_out_low,
  input wire logic [7:0]  o_flop_outputs,
  input wire logic        o_carry_out
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  sequence s_access;
    i_psel && i_penable && !o_pready;
  endsequence
  sequence s_answer;
    o_pready ##1 !o_pready;
  endsequence
  // three cycles of margin for a registered enable or config write
  sequence s_quiet_lo;
    (!i_clock_enable[0] && !i_local_set_reset[0] && !o_pready) [*3];
  endsequence
  sequence s_force_hi;
    (i_local_set_reset[1] && !o_pready) [*3];
  endsequence
  apb_wait_a: assert property (s_access |=> s_answer)
    else $error("answer not after one wait state");
  ready_cause_a: assert property (
    o_pready |-> i_psel && i_penable && $past(i_penable))
    else $error("ready outside an access");
  idle_ready_a: assert property (!i_psel |=> !o_pready)
    else $error("ready without select");
  err_qual_a: assert property (o_pslverr |-> o_pready)
    else $error("error without ready");
  rdata_hold_a: assert property (
    $changed(o_prdata) |-> o_pready && !i_pwrite)
    else $error("read data moved outside a read");
  err_rdata_a: assert property (
    o_pslverr && !i_pwrite |-> o_prdata == 32'h0)
    else $error("refused read left stale data");
  reset_flops_a: assert property ($fell(i_rst) |->
    o_flop_outputs == 8'h00 && o_comb_out_low == 4'h0 && !o_carry_out)
    else $error("outputs not clear after reset");
  ce_hold_a: assert property (
    s_quiet_lo |=> $stable(o_flop_outputs[3:0]))
    else $error("pair 0 flops moved with enable low");
  lsr_hold_a: assert property (
    s_force_hi |=> $stable(o_flop_outputs[7:4]))
    else $error("pair 1 flops moved under set/reset");
endmodule // lpt_tile_properties

bind lpt_logic_tile lpt_tile_properties i_props (
  .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .o_prdata(o_prdata),
  .o_pready(o_pready), .o_pslverr(o_pslverr),
  .i_clock_enable(i_clock_enable), .i_local_set_reset(i_local_set_reset),
  .o_comb_out_low(o_comb_out_low), .o_flop_outputs(o_flop_outputs),
  .o_carry_out(o_carry_out));

// ==== sim/lpt_logic_tile_test.sv ====
`timescale 1ns/1ps
module lpt_logic_tile_test;
  import lpt_pkg::*;
  typedef struct packed {
    logic [15:0] lo;
    logic [15:0] hi;
    logic [3:0]  sel;
    logic [3:0]  el;
    logic [3:0]  eh;
  } lpt_row_t;
  // slice s tables: low true only at 15-s, high true only at s
  localparam lpt_row_t ROWS [5] = '{
    '{16'hcdef, 16'h3210, 4'h0, 4'hf, 4'hf},
    '{16'h0000, 16'h0000, 4'h0, 4'h0, 4'h1},
    '{16'h0000, 16'hffff, 4'h1, 4'h1, 4'h0},
    '{16'hcdef, 16'h3210, 4'hf, 4'he, 4'hf},
    '{16'hcdee, 16'h3211, 4'h0, 4'he, 4'he}};
  logic        clk, rst, psel, pen, pwr, pready, pslverr, cout, rerr, cin;
  logic [7:0]  paddr, dir, fq, snap;
  logic [31:0] pwdata, prdata, rdat;
  logic [15:0] tlo, thi;
  logic [3:0]  sel, clo, chi;
  logic [1:0]  ce, local_set_reset, go, sclk;
  int          err_total, n_compared;

  lpt_fabric_model i_fabric (.i_clk_sys(clk), .i_rst(rst), .i_go(go),
    .o_slice_clock(sclk));
  lpt_logic_tile i_dut (
    .i_clk_sys(clk), .i_rst(rst), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_table_low_inputs(tlo), .i_table_high_inputs(thi),
    .i_direct_flop_inputs(dir), .i_combine_select(sel),
    .i_slice_clock(sclk), .i_clock_enable(ce),
    .i_local_set_reset(local_set_reset), .i_carry_in(cin),
    .o_comb_out_low(clo), .o_comb_out_high(chi),
    .o_flop_outputs(fq), .o_carry_out(cout));

  // ****
  // tasks
  // ****
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // read data and error are taken at the edge that sees ready high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk("apb ready", 32'(pready), 32'h1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic load(input logic [3:0][12:0] sc);
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, 8'(8'h10 + 8 * s), {16'h1 << s, 16'h8000 >> s});
      apb(1'b1, 8'(8'h14 + 8 * s), 32'(sc[s]));
    end
  endtask
  task automatic drv(input logic [15:0] lo, hi, input logic [3:0] s);
    @(posedge clk);
    tlo <= lo;
    thi <= hi;
    sel <= s;
  endtask
  // snap holds the flops seen in the last cycle of the high phase
  task automatic pulse(input int p);
    @(posedge clk);
    go[p] <= 1'b1;
    @(posedge clk);
    go[p] <= 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    snap = fq;
    repeat (5) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic do_reset;
    @(posedge clk);
    rst <= 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
  endtask

  // ****
  // sequence
  // ****
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    test_done();
  end
  initial begin
    rst = 1'b1;
    {psel, pen, pwr, paddr, pwdata} = '0;
    {tlo, thi, dir, sel, ce, local_set_reset, go, cin} = '0;
    err_total = 0;
    n_compared = 0;
    do_reset();
    chk("reset flops", 32'(fq), 32'h0);
    apb(1'b0, 8'h00, 32'h0);
    chk("tile ctrl", rdat, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk("table", rdat, 32'h0);
    load({13'h040, 13'h003, 13'h008, 13'h024});
    apb(1'b0, 8'h14, 32'h0);
    chk("slice ctrl", rdat, 32'h24);
    apb(1'b0, 8'h08, 32'h0);
    chk("unmapped err", 32'(rerr), 32'h1);
    chk("unmapped data", rdat, 32'h0);
    apb(1'b1, 8'h00, 32'h2);
    repeat (3) @(posedge clk);
    chk("user entry flops", 32'(fq), 32'h81);
    apb(1'b1, 8'h10, 32'hffff_ffff);
    apb(1'b0, 8'h10, 32'h0);
    chk("frozen table", rdat, 32'h0001_8000);
    foreach (ROWS[i]) begin
      drv(ROWS[i].lo, ROWS[i].hi, ROWS[i].sel);
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk("comb low", 32'(clo), 32'(ROWS[i].el));
      chk("comb high", 32'(chi), 32'(ROWS[i].eh));
    end
    drv(16'hcdef, 16'h3210, 4'h0);
    ce <= 2'h3;
    pulse(0);
    chk("pair0 rise", 32'(snap), 32'h8b);
    pulse(1);
    chk("pair1 rise", 32'(snap[7:4]), 32'h8);
    chk("pair1 fall", 32'(fq), 32'hfb);
    apb(1'b0, 8'h04, 32'h0);
    chk("status", 32'(rdat[7:0]), 32'hfb);
    drv(16'h0000, 16'hffff, 4'h0);
    ce <= 2'h0;
    pulse(0);
    pulse(1);
    chk("enable hold", 32'(fq), 32'hfb);
    @(posedge clk);
    local_set_reset <= 2'h3;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk("async force", 32'(fq), 32'h8b);
    pulse(0);
    chk("sync force", 32'(fq), 32'h81);
    @(posedge clk);
    local_set_reset <= 2'h0;
    do_reset();
    chk("reset flops", 32'(fq), 32'h0);
    load({13'h080, 13'h100, 13'h100, 13'h100});
    apb(1'b1, 8'h00, 32'h3);
    drv(16'hcdef, 16'h3210, 4'h0);
    ce <= 2'h3;
    pulse(0);
    pulse(1);
    chk("ram comb low", 32'(clo[3:2]), 32'h2);
    chk("ram comb high", 32'(chi[3:2]), 32'h2);
    chk("ram flops", 32'(fq[7:4]), 32'hc);
    // slice 2 low nibble is the write address, direct bit 4 the strobe
    drv(16'hc5ef, 16'h3210, 4'h0);
    dir <= 8'h15;
    pulse(1);
    apb(1'b0, 8'h10, 32'h0);
    chk("ram write s0", rdat, 32'h0001_8020);
    apb(1'b0, 8'h18, 32'h0);
    chk("ram write s1", rdat, 32'h0002_4020);
    // slice 3 adds 0 + 3 + carry-in: sum wraps to 0, carry leaves
    cin <= 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("ripple sum", 32'({chi[3], clo[3]}), 32'h0);
    chk("carry out", 32'(cout), 32'h1);
    test_done();
  end
endmodule // lpt_logic_tile_test
